// ### tb/pia_arbiter_props.sv
// Assertion checker for the arbiter ports
`timescale 1ns/1ps
module pia_arbiter_props (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [pia_pkg::BASE_W-1:0] vectorBase,
  input wire pia_pkg::pia_fast_cfg_t fastMatchZero,
  input wire logic [1:0] coreMask,
  input wire logic lowPower,
  input wire logic irqPending_r,
  input wire logic fastIrq_r,
  input wire logic fastChannel_r,
  input wire logic [pia_pkg::VEC_W-1:0] vectorNum_r,
  input wire logic [pia_pkg::ADDR_W-1:0] vectorAddr_r,
  input wire logic [pia_pkg::LEVEL_W-1:0] presentedLevel_r,
  input wire logic bootFetch_r,
  input wire logic clockRestart_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_enter;
    !lowPower ##1 lowPower;
  endsequence
  ////////////////////////////////////////////////////////////
  AST_BOOT: assert property ($rose(resetn) |=> bootFetch_r && vectorAddr_r == 0) else $error("no boot");
  AST_IDLE: assert property (!irqPending_r && !bootFetch_r |-> presentedLevel_r == 2'h0) else $error("idle");
  AST_MASK: assert property (irqPending_r |-> presentedLevel_r == 2'h3 || presentedLevel_r > $past(coreMask))
    else $error("mask");
  AST_FLVL: assert property (fastIrq_r |-> irqPending_r && presentedLevel_r == 2'h3) else $error("fast lvl");
  AST_FAST0: assert property (fastIrq_r && !fastChannel_r |-> vectorNum_r == $past(fastMatchZero.match) &&
    vectorAddr_r == {$past(fastMatchZero.addrHigh), $past(fastMatchZero.addrLow)}) else $error("fast0");
  AST_NORM: assert property (irqPending_r && !fastIrq_r |-> vectorAddr_r == {$past(vectorBase), vectorNum_r})
    else $error("normal");
  AST_WAKE: assert property (clockRestart_r |-> $past(lowPower)) else $error("wake");
  AST_EARLY: assert property (s_enter |=> !clockRestart_r) else $error("early wake");
endmodule // pia_arbiter_props
bind pia_arbiter pia_arbiter_props props_u (.*);

// ### tb/pia_core_model.sv
// Core-side model: mask register that nesting raises
`timescale 1ns/1ps
module pia_core_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic nest,
  input wire logic [1:0] swMask,
  input wire logic irqPending_r,
  input wire logic [1:0] presentedLevel_r,
  output logic [1:0] coreMask
);
  // Taking a request at level 0 to 2 masks its own level, so only higher ones nest; level 3 still nests
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) coreMask <= 2'h0;
    else if (!nest) coreMask <= swMask;
    else if (irqPending_r) coreMask <= presentedLevel_r;
  end
endmodule // pia_core_model

// ### tb/testbench.sv
// Self-checking bench for the arbiter
`timescale 1ns/1ps
module testbench;
  logic clock = 0, resetn = 0, lowPower = 0, nest = 0;
  logic [63:0] irqReq = 0, irqEnable = 0;
  logic [63:0][1:0] priorityAssign = 0;
  logic [13:0] vectorBase = 0;
  logic [1:0] swMask = 0, coreMask, presentedLevel_r;
  pia_pkg::pia_fast_cfg_t fastMatchZero = 0, fastMatchOne = 0;
  logic irqPending_r, fastIrq_r, fastChannel_r, bootFetch_r, clockRestart_r;
  logic [6:0] vectorNum_r;
  logic [20:0] vectorAddr_r;
  logic [31:0] seed = 32'hA4B4F1FE;
  int failures = 0, n_compared = 0;
  always #12.5 clock = ~clock;
  pia_arbiter dut_u (.*);
  pia_core_model core_u (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic step();
    int w, lv;
    logic hit, fast;
    logic [6:0] v;
    logic [20:0] a;
    w = -1;
    lv = 0;
    for (int l = 3; l >= 0 && w < 0; l--)
      for (int i = 63; i >= 0; i--)
        if (irqReq[i] && irqEnable[i] && l == (pia_pkg::FIXED_MASK[i] ? 3 : priorityAssign[i])) begin
          w = i;
          lv = l;
        end
    hit = w >= 0 && lv >= coreMask;
    v = 7'(w) + pia_pkg::VEC_OFFSET;
    fast = lv == 2 && (v == fastMatchZero.match || v == fastMatchOne.match);
    // Fast address is high field over low field, not the struct's low bits
    a = !fast ? {vectorBase, v} : v == fastMatchZero.match ? {fastMatchZero.addrHigh, fastMatchZero.addrLow} :
      {fastMatchOne.addrHigh, fastMatchOne.addrLow};
    @(posedge clock);
    #1;
    check(irqPending_r, hit);
    check(presentedLevel_r, hit ? (lv > 1 ? 3 : lv + 1) : 0);
    if (hit) begin
      check(vectorNum_r, v);
      check(fastIrq_r, fast);
      check(vectorAddr_r, a);
      if (fast) check(fastChannel_r, v != fastMatchZero.match);
    end
  endtask
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clock);
    #1;
    resetn = 1;
    @(posedge clock);
    #1;
    check(bootFetch_r, 1);
    irqEnable = '1;
    irqReq = 64'h8000_0000_0000_0000;
    step();
    irqReq = '1;
    priorityAssign = {64{2'h2}};
    fastMatchZero = {7'h12, 16'hBEEF, 5'h15};
    fastMatchOne = {7'h12, 16'h1234, 5'h0A};
    step();
    irqEnable = ~64'h3;
    for (int m = 0; m < 4; m++) begin
      swMask = 2'(m);
      step();
    end
    $display("test corners done");
    for (int n = 0; n < 400; n++) begin
      irqReq = {rnd(), rnd()} & {rnd(), rnd()} & {rnd(), rnd()};
      irqEnable = ~({rnd(), rnd()} & {rnd(), rnd()});
      priorityAssign = {rnd(), rnd(), rnd(), rnd()};
      vectorBase = 14'(rnd());
      swMask = 2'(rnd());
      nest = n[4];
      fastMatchZero = {7'h12 + 7'(rnd() & 7), 21'(rnd())};
      fastMatchOne = n[0] ? fastMatchZero : {7'h12 + 7'(rnd() & 7), 21'(rnd())};
      step();
    end
    $display("test random done");
    {nest, irqReq, irqEnable, lowPower} = {1'b0, 64'h0, 64'h8, 1'b1};
    step();
    irqReq = 64'h8;
    repeat (2) step();
    check(clockRestart_r, 1);
    {irqReq, irqEnable} = {64'h10, 64'h18};
    repeat (2) step();
    check(clockRestart_r, 0);
    $display("test wake done");
    stop_test();
  end
endmodule // testbench

// ### verilog/pia_arbiter.sv
// Priority interrupt arbiter top: level arbitration, vectoring, fast channels, wake-up
`timescale 1ns/1ps
module pia_arbiter (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [pia_pkg::NUM_SRC-1:0] irqReq,
  input wire logic [pia_pkg::NUM_SRC-1:0] irqEnable,
  input wire logic [pia_pkg::NUM_SRC-1:0][pia_pkg::LEVEL_W-1:0] priorityAssign,
  input wire logic [pia_pkg::BASE_W-1:0] vectorBase,
  input wire pia_pkg::pia_fast_cfg_t fastMatchZero,
  input wire pia_pkg::pia_fast_cfg_t fastMatchOne,
  input wire logic [1:0] coreMask,
  input wire logic lowPower,
  output logic irqPending_r,
  output logic fastIrq_r,
  output logic fastChannel_r,
  output logic [pia_pkg::VEC_W-1:0] vectorNum_r,
  output logic [pia_pkg::ADDR_W-1:0] vectorAddr_r,
  output logic [pia_pkg::LEVEL_W-1:0] presentedLevel_r,
  output logic bootFetch_r,
  output logic clockRestart_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-level request vectors
  logic [pia_pkg::NUM_LEVEL-1:0][pia_pkg::NUM_SRC-1:0] levelReq;
  logic [pia_pkg::NUM_LEVEL-1:0] levelValid;
  logic [pia_pkg::NUM_LEVEL-1:0][pia_pkg::SRC_W-1:0] levelIndex;

  always_comb begin
    for (int l = 0; l < pia_pkg::NUM_LEVEL; l++) begin
      for (int i = 0; i < pia_pkg::NUM_SRC; i++) begin
        // Fixed sources ignore software priority
        levelReq[l][i] = irqReq[i] & irqEnable[i] &
          ((pia_pkg::FIXED_MASK[i] ? pia_pkg::FIXED_LEVEL : priorityAssign[i]) == l[1:0]);
      end
    end
  end

  generate
    for (genvar g = 0; g < pia_pkg::NUM_LEVEL; g++) begin : gLevel
      pia_level_encoder #(.N(pia_pkg::NUM_SRC), .W(pia_pkg::SRC_W)) uEnc (
        .req(levelReq[g]),
        .valid(levelValid[g]),
        .index(levelIndex[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Cross-level winner and vector formation
  pia_pkg::pia_present_t win;
  logic [pia_pkg::SRC_W-1:0] winIdx;
  logic [pia_pkg::NUM_FAST-1:0] fastHit;

  always_comb begin
    win = '0;
    winIdx = '0;
    for (int l = 0; l < pia_pkg::NUM_LEVEL; l++) begin
      if (levelValid[l]) begin
        win.pending = 1'b1;
        win.level = l[1:0];
        winIdx = levelIndex[l];
      end
    end
    win.vecNum = pia_pkg::VEC_OFFSET + {1'b0, winIdx};
    // Level filter the core applies; also lets a higher request nest
    win.pending = win.pending && (win.level >= coreMask);
    fastHit[0] = win.level == pia_pkg::FAST_LEVEL && win.vecNum == fastMatchZero.match;
    fastHit[1] = win.level == pia_pkg::FAST_LEVEL && win.vecNum == fastMatchOne.match;
    win.fast = win.pending && (|fastHit);
    if (win.fast && fastHit[0]) begin
      win.addr = {fastMatchZero.addrHigh, fastMatchZero.addrLow};
    end else if (win.fast) begin
      win.addr = {fastMatchOne.addrHigh, fastMatchOne.addrLow};
    end else begin
      win.addr = {vectorBase, win.vecNum};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Presentation registers, boot fetch and wake-up
  pia_pkg::pia_state_t state_r;
  pia_pkg::pia_state_t state_nxt;
  logic irqPending_nxt;
  logic fastIrq_nxt;
  logic fastChannel_nxt;
  logic [pia_pkg::VEC_W-1:0] vectorNum_nxt;
  logic [pia_pkg::ADDR_W-1:0] vectorAddr_nxt;
  logic [pia_pkg::LEVEL_W-1:0] presentedLevel_nxt;
  logic bootFetch_nxt;
  logic lowPower_r;
  logic [pia_pkg::NUM_SRC-1:0] wakeEnable_r;
  logic [pia_pkg::NUM_SRC-1:0] wakeEnable_nxt;
  logic clockRestart_nxt;

  always_comb begin
    state_nxt = pia_pkg::PIA_RUN;
    bootFetch_nxt = 1'b0;
    irqPending_nxt = win.pending;
    fastIrq_nxt = win.fast;
    fastChannel_nxt = win.fast && !fastHit[0];
    vectorNum_nxt = win.vecNum;
    vectorAddr_nxt = win.addr;
    unique case (state_r)
      pia_pkg::PIA_BOOT: begin
        // One cycle of the initial fetch address before arbitration takes over
        bootFetch_nxt = 1'b1;
        irqPending_nxt = 1'b0;
        fastIrq_nxt = 1'b0;
        fastChannel_nxt = 1'b0;
        vectorAddr_nxt = pia_pkg::BOOT_ADDR;
      end
      pia_pkg::PIA_RUN: begin
      end
    endcase
    if (!irqPending_nxt) begin
      presentedLevel_nxt = pia_pkg::STAT_NONE;
    end else begin
      unique case (win.level)
        2'h0: presentedLevel_nxt = pia_pkg::STAT_P0;
        2'h1: presentedLevel_nxt = pia_pkg::STAT_P1;
        default: presentedLevel_nxt = pia_pkg::STAT_P23;
      endcase
    end
    // Enables are frozen at entry so later enables cannot wake the core
    wakeEnable_nxt = (lowPower && !lowPower_r) ? irqEnable : wakeEnable_r;
    clockRestart_nxt = lowPower && lowPower_r && |(irqReq & wakeEnable_r);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= pia_pkg::PIA_BOOT;
      bootFetch_r <= 1'b0;
      irqPending_r <= 1'b0;
      fastIrq_r <= 1'b0;
      fastChannel_r <= 1'b0;
      vectorNum_r <= '0;
      vectorAddr_r <= pia_pkg::BOOT_ADDR;
      presentedLevel_r <= pia_pkg::STAT_NONE;
      lowPower_r <= 1'b0;
      wakeEnable_r <= '0;
      clockRestart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bootFetch_r <= bootFetch_nxt;
      irqPending_r <= irqPending_nxt;
      fastIrq_r <= fastIrq_nxt;
      fastChannel_r <= fastChannel_nxt;
      vectorNum_r <= vectorNum_nxt;
      vectorAddr_r <= vectorAddr_nxt;
      presentedLevel_r <= presentedLevel_nxt;
      lowPower_r <= lowPower;
      wakeEnable_r <= wakeEnable_nxt;
      clockRestart_r <= clockRestart_nxt;
    end
  end

endmodule // pia_arbiter

// ### verilog/pia_level_encoder.sv
// Lowest-index-wins priority encoder for one level
`timescale 1ns/1ps
module pia_level_encoder #(
  parameter int N = 64,
  parameter int W = 6
) (
  input wire logic [N-1:0] req,
  output logic valid,
  output logic [W-1:0] index
);
  always_comb begin
    valid = |req;
    index = '0;
    // Descending scan so the lowest active index is left last
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        index = W'(i);
      end
    end
  end
endmodule // pia_level_encoder

// ### verilog/pia_pkg.sv
// Package of constants and carrier types for the priority interrupt arbiter
package pia_pkg;
  localparam int NUM_SRC = 64;
  localparam int SRC_W = 6;
  localparam int LEVEL_W = 2;
  localparam int NUM_LEVEL = 4;
  localparam int VEC_W = 7;
  localparam int BASE_W = 14;
  localparam int FAST_LOW_W = 16;
  localparam int FAST_HIGH_W = 5;
  localparam int ADDR_W = 21;
  localparam int NUM_FAST = 2;
  // Vector number of source 0; low slots belong to core exceptions
  localparam logic [VEC_W-1:0] VEC_OFFSET = 7'h10;
  // Sources whose level software cannot change, and that level
  localparam logic [NUM_SRC-1:0] FIXED_MASK = 64'h0000_0000_0000_0003;
  localparam logic [LEVEL_W-1:0] FIXED_LEVEL = 2'h3;
  localparam logic [LEVEL_W-1:0] FAST_LEVEL = 2'h2;
  localparam logic [ADDR_W-1:0] BOOT_ADDR = 21'h00_0000;
  localparam logic [LEVEL_W-1:0] STAT_NONE = 2'h0;
  localparam logic [LEVEL_W-1:0] STAT_P0 = 2'h1;
  localparam logic [LEVEL_W-1:0] STAT_P1 = 2'h2;
  localparam logic [LEVEL_W-1:0] STAT_P23 = 2'h3;

  typedef struct packed {
    logic [VEC_W-1:0] match;
    logic [FAST_LOW_W-1:0] addrLow;
    logic [FAST_HIGH_W-1:0] addrHigh;
  } pia_fast_cfg_t;

  typedef struct packed {
    logic pending;
    logic fast;
    logic [LEVEL_W-1:0] level;
    logic [VEC_W-1:0] vecNum;
    logic [ADDR_W-1:0] addr;
  } pia_present_t;

  typedef enum logic [0:0] {PIA_BOOT, PIA_RUN} pia_state_t;
endpackage
